// ### hdl/bbr_bus_if.sv
/*
  bbr_bus_if: processor bus between the sequencer and the outside world.
  Assumes the testbench resolves the shared pins from the output enables.
*/
`timescale 1ns/10ps
`default_nettype none
interface bbr_bus_if
  import bbr_pkg::*;
(
  input wire logic core_clk_i
);
  // processor-driven pins, with separate address and data output enables
  logic [BBR_ADDR_W-1:0] addr;
  bbr_attr_type attr;
  logic address_strobe_n;
  logic last_transfer_n;
  logic [BBR_DATA_W-1:0] wdata;
  logic [BBR_DP_W-1:0] wparity;
  logic addr_oe;   // address, status, strobe, last
  logic data_oe;   // data and parity
  logic hold_acknowledge;
  // system-driven pins
  logic [BBR_DATA_W-1:0] rdata;
  logic ready_n;
  logic burst_ready_n;
  logic backoff_request_n;
  logic bus_size_byte_n;
  logic bus_size_halfword_n;
  logic address_hold_request;

  modport cpu (
    input core_clk_i, rdata, ready_n, burst_ready_n, backoff_request_n,
    bus_size_byte_n, bus_size_halfword_n,
    output addr, attr, address_strobe_n, last_transfer_n, wdata, wparity,
    addr_oe, data_oe, hold_acknowledge
  );
  modport sys (
    input core_clk_i, addr, attr, address_strobe_n, last_transfer_n, wdata,
    wparity, addr_oe, data_oe, hold_acknowledge,
    output rdata, ready_n, burst_ready_n, backoff_request_n, bus_size_byte_n,
    bus_size_halfword_n, address_hold_request
  );
endinterface
`default_nettype wire

// ### hdl/bbr_cpu_end.sv
/*
  bbr_cpu_end: processor bus-cycle sequencer with backoff and restart.
  Assumes bus pins arrive from another domain and are synchronised here;
  the user side issues one request and waits for done.
  // Operation
  // [R1] sample backoff on every clock edge
  // [R2] float address, data, status next clock
  // [R3] abort cycle, discard its read data
  // [R4] float hold set, never acknowledge hold
  // [R5] backoff beats ready in same clock
  // [R6] new master waits for ready first
  // [R7] idle bus: master starts two clocks later
  // [R8] memory treats backoff as last transfer
  // [R9] stay floated, then restart with strobe
  // [R10] keep acknowledged transfers, restart remainder
  // [R11] backoff with strobe floats strobe low
  // [R12] system ignores strobe or uses hold
  // [R13] idle drives nothing, bus floated
  // [R14] first clock drives address, asserts strobe
  // [R15] data phase drives data, samples ready
  // [R16] restart first clock is own state
  // [R17] aborted clocks form their own state
  // [R18] floated set: enables, status, data, parity
  // [R19] hold address and position while backed off
*/
`timescale 1ns/10ps
`default_nettype none
module bbr_cpu_end
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  bbr_bus_if.cpu bus,
  input wire logic req_valid_i,
  input wire logic [BBR_ADDR_W-1:0] req_addr_i,
  input wire bbr_attr_type req_attr_i,
  input wire logic req_burst_i,
  input wire logic [BBR_DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [BBR_DATA_W-1:0] rsp_rdata_o,
  output logic [BBR_XFER_W-1:0] rsp_index_o,
  output logic rsp_last_o
);
  bbr_state_type state_q;
  logic [1:0] backoff_request_n_sync_q, rdy_sync_q, burst_ready_n_sync_q;
  logic [BBR_DATA_W-1:0] rdata_sync_q;
  logic [BBR_DATA_W-1:0] rdata_q;
  logic strobe_hold_q;
  logic strobe_drive;
  logic addr_drive;
  logic [BBR_ADDR_W-1:0] addr_q;
  bbr_attr_type attr_q;
  logic [BBR_DATA_W-1:0] wdata_q;
  logic [BBR_XFER_W-1:0] xfer_q;
  logic burst_q;
  logic backoff;
  logic term;
  logic last_xfer;
  logic rsp_valid_q;
  logic [BBR_DATA_W-1:0] rsp_rdata_q;
  logic [BBR_XFER_W-1:0] rsp_index_q;
  logic rsp_last_q;

  // two-stage synchronisers on inbound pins, sampled every clock
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      backoff_request_n_sync_q <= 2'h3;
      rdy_sync_q <= 2'h3;
      burst_ready_n_sync_q <= 2'h3;
      rdata_sync_q <= BBR_DATA_RESET;
      rdata_q <= BBR_DATA_RESET;
    end
    else
    begin
      backoff_request_n_sync_q <= {backoff_request_n_sync_q[0], bus.backoff_request_n}; // [R1]
      rdy_sync_q <= {rdy_sync_q[0], bus.ready_n};
      burst_ready_n_sync_q <= {burst_ready_n_sync_q[0], bus.burst_ready_n};
      rdata_sync_q <= bus.rdata; // two stages keep read data in step with ready and backoff
      rdata_q <= rdata_sync_q;
    end
  end

  assign backoff = !backoff_request_n_sync_q[1];
  // termination only counts when backoff is absent
  assign term = (!rdy_sync_q[1] || !burst_ready_n_sync_q[1]) && !backoff; // [R5]
  assign last_xfer = !burst_q || (xfer_q == BBR_LAST_XFER_BURST);

  // bus state machine
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state_q <= bbr_bus_idle_clock;
    else
    begin
      case (state_q)
        bbr_bus_idle_clock:
          if (req_valid_i && !backoff)
            state_q <= bbr_first_cycle_clock; // [R14]
        bbr_first_cycle_clock:
          if (backoff)
            state_q <= bbr_aborted_cycle_clock; // [R11]
          else
            state_q <= bbr_data_phase_clock;
        bbr_data_phase_clock:
          if (backoff)
            state_q <= bbr_aborted_cycle_clock; // [R3]
          else if (term && last_xfer)
            state_q <= bbr_bus_idle_clock;
        bbr_restart_first_clock:
          if (backoff)
            state_q <= bbr_aborted_cycle_clock;
          else
            state_q <= bbr_data_phase_clock; // [R16]
        bbr_aborted_cycle_clock:
          if (!backoff)
            state_q <= bbr_restart_first_clock; // [R9] [R17]
        default:
          state_q <= bbr_bus_idle_clock;
      endcase
    end
  end

  // cycle context, kept unchanged through backoff
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      addr_q <= BBR_ADDR_RESET;
      attr_q <= '0;
      wdata_q <= BBR_DATA_RESET;
      xfer_q <= '0;
      burst_q <= 1'b0;
    end
    else if (state_q == bbr_bus_idle_clock && req_valid_i && !backoff)
    begin
      addr_q <= req_addr_i;
      attr_q <= req_attr_i;
      wdata_q <= req_wdata_i;
      xfer_q <= '0;
      burst_q <= req_burst_i;
    end
    else if (state_q == bbr_data_phase_clock && term && !last_xfer)
    begin
      xfer_q <= xfer_q + 2'h1; // [R10] [R19]
      addr_q <= {addr_q[BBR_ADDR_W-1:2], addr_q[1:0] + 2'h1};
    end
  end

  // accepted read data; aborted transfer returns nothing
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= BBR_DATA_RESET;
      rsp_index_q <= '0;
      rsp_last_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= (state_q == bbr_data_phase_clock) && term; // [R3] [R15]
      if ((state_q == bbr_data_phase_clock) && term)
      begin
        rsp_rdata_q <= rdata_q;
        rsp_index_q <= xfer_q;
        rsp_last_q <= last_xfer;
      end
    end
  end

  assign req_ready_o = (state_q == bbr_bus_idle_clock) && !backoff;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_rdata_o = rsp_rdata_q;
  assign rsp_index_o = rsp_index_q;
  assign rsp_last_o = rsp_last_q;

  // pins are driven only in first, data and restart clocks
  assign addr_drive = (state_q == bbr_first_cycle_clock) ||
                      (state_q == bbr_data_phase_clock) ||
                      (state_q == bbr_restart_first_clock); // [R2] [R13] [R18]
  assign strobe_drive = !((state_q == bbr_first_cycle_clock) ||
                          (state_q == bbr_restart_first_clock)); // [R14] [R16]

  // floated strobe keeps its last driven level, low when cut in its own clock
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      strobe_hold_q <= 1'b1;
    else if (addr_drive)
      strobe_hold_q <= strobe_drive; // [R11]
  end

  // pin drive: floated in idle and aborted clocks, full hold set
  always_comb
  begin
    bus.addr_oe = addr_drive;
    bus.data_oe = (state_q == bbr_data_phase_clock) && attr_q.write_not_read; // [R15]
    bus.addr = addr_q; // [R19]
    bus.attr = attr_q;
    bus.address_strobe_n = addr_drive ? strobe_drive : strobe_hold_q; // [R11]
    bus.last_transfer_n = !last_xfer;
    bus.wdata = wdata_q;
    bus.wparity = {^wdata_q[31:24], ^wdata_q[23:16], ^wdata_q[15:8], ^wdata_q[7:0]};
    bus.hold_acknowledge = 1'b0; // [R4]
  end
endmodule
`default_nettype wire

// ### hdl/bbr_pkg.sv
/*
  bbr_pkg: shared constants and types for the bus backoff and restart
  sequencer and its far-end partner.
  Assumes a single processor clock and a synchronous active-high reset.
*/
package bbr_pkg;
  localparam int BBR_ADDR_W = 30;            // address bits 31..2
  localparam int BBR_DATA_W = 32;
  localparam int BBR_BE_W = 4;
  localparam int BBR_DP_W = 4;
  localparam int BBR_XFER_W = 2;             // transfer position in a burst
  localparam logic [1:0] BBR_LAST_XFER_SINGLE = 2'h0;
  localparam logic [1:0] BBR_LAST_XFER_BURST = 2'h3;
  localparam logic [BBR_DATA_W-1:0] BBR_DATA_RESET = 32'h0000_0000;
  localparam logic [BBR_ADDR_W-1:0] BBR_ADDR_RESET = 30'h0000_0000;
  localparam int BBR_IDLE_START_CLOCKS = 2;  // new master may start two clocks after backoff

  // bus sequencer states
  typedef enum logic [2:0] {
    bbr_bus_idle_clock,
    bbr_first_cycle_clock,
    bbr_data_phase_clock,
    bbr_restart_first_clock,
    bbr_aborted_cycle_clock
  } bbr_state_type;

  // cycle attributes: byte enables, cache control, cycle definition, lock
  typedef struct packed {
    logic [BBR_BE_W-1:0] byte_enable_n;
    logic page_cache_disable;
    logic page_write_through;
    logic write_not_read;
    logic data_not_code;
    logic memory_not_io;
    logic lock_n;
    logic pseudo_lock_n;
  } bbr_attr_type;
endpackage

// ### hdl/bbr_sys_end.sv
/*
  bbr_sys_end: memory and alternate master side of the processor bus.
  Assumes the processor pins are synchronised here with two flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none
module bbr_sys_end
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  bbr_bus_if.sys bus,
  input wire logic backoff_i,
  input wire logic hold_addr_i,
  input wire logic ready_i,
  input wire logic burst_ready_i,
  input wire logic [BBR_DATA_W-1:0] rdata_i,
  output logic cycle_seen_o,
  output logic may_drive_o
);
  logic [1:0] ads_sync_q;
  logic [1:0] aoe_sync_q;
  logic backoff_request_n_q;
  logic [1:0] idle_cnt_q;
  logic busy_q;
  logic may_q;
  logic seen_q;

  // outputs to the processor, registered
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      bus.backoff_request_n <= 1'b1;
      bus.ready_n <= 1'b1;
      bus.burst_ready_n <= 1'b1;
      bus.rdata <= BBR_DATA_RESET;
      bus.address_hold_request <= 1'b0;
      backoff_request_n_q <= 1'b0;
    end
    else
    begin
      bus.backoff_request_n <= !backoff_i; // [R8]
      bus.ready_n <= !ready_i;
      bus.burst_ready_n <= !burst_ready_i;
      bus.rdata <= rdata_i;
      bus.address_hold_request <= hold_addr_i; // [R12]
      backoff_request_n_q <= backoff_i;
    end
  end
  assign bus.bus_size_byte_n = 1'b1;
  assign bus.bus_size_halfword_n = 1'b1;

  // processor strobe and drive state, synchronised
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ads_sync_q <= 2'h3;
      aoe_sync_q <= 2'h0;
    end
    else
    begin
      ads_sync_q <= {ads_sync_q[0], bus.address_strobe_n};
      aoe_sync_q <= {aoe_sync_q[0], bus.addr_oe};
    end
  end

  // track whether a processor cycle is open; floated strobe ignored, strobe wins over ready
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      busy_q <= 1'b0;
    else if (!ads_sync_q[1] && aoe_sync_q[1])
      busy_q <= 1'b1; // [R12]
    else if (ready_i || burst_ready_i)
      busy_q <= 1'b0;
  end

  // when the alternate master may take the bus
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      idle_cnt_q <= '0;
      may_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      seen_q <= busy_q;
      if (!backoff_request_n_q)
      begin
        idle_cnt_q <= '0;
        may_q <= 1'b0;
      end
      else if (!busy_q)
      begin
        if (idle_cnt_q != 2'(BBR_IDLE_START_CLOCKS))
          idle_cnt_q <= idle_cnt_q + 2'h1;
        may_q <= (idle_cnt_q + 2'h1) >= 2'(BBR_IDLE_START_CLOCKS); // [R7]
      end
      else
        may_q <= 1'b0; // [R6]
    end
  end
  assign may_drive_o = may_q;
  assign cycle_seen_o = seen_q;
endmodule
`default_nettype wire

// ### verif/bbr_checker.sv
/*
  bbr_checker: pin-level backoff and restart checks on the shared bus.
  Assumes it is instantiated beside the interface joining both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module bbr_checker
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [BBR_ADDR_W-1:0] addr,
  input wire bbr_attr_type attr,
  input wire logic address_strobe_n,
  input wire logic [BBR_DATA_W-1:0] wdata,
  input wire logic [BBR_DP_W-1:0] wparity,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic hold_acknowledge,
  input wire logic backoff_request_n
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  logic [1:0] backoff_request_n_pipe_q;
  logic abort_q;
  // backoff as the processor acts on it, after its two input flops
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      backoff_request_n_pipe_q <= 2'h0;
    else
      backoff_request_n_pipe_q <= {backoff_request_n_pipe_q[0], !backoff_request_n};
  end
  // remembers a cycle cut by backoff until its restart strobe; a new cut wins
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      abort_q <= 1'b0;
    else if (backoff_request_n_pipe_q[1] && addr_oe)
      abort_q <= 1'b1;
    else if (addr_oe && !address_strobe_n)
      abort_q <= 1'b0;
  end
  no_hold_ack_a: assert property (!hold_acknowledge)
    else $error("hold acknowledge raised");
  backoff_float_a: assert property (!backoff_request_n [*4] |-> !addr_oe && !data_oe)
    else $error("bus driven during backoff");
  strobe_pulse_a: assert property (addr_oe && !address_strobe_n |=> address_strobe_n || !addr_oe)
    else $error("strobe longer than one clock");
  addr_hold_a: assert property (!backoff_request_n [*5] |-> $stable(addr) && $stable(attr))
    else $error("request changed while backed off");
  restart_strobe_a: assert property ($rose(backoff_request_n) && abort_q |-> ##[1:8] addr_oe && !address_strobe_n)
    else $error("no restart after backoff");
  write_data_a: assert property (data_oe |-> attr.write_not_read && addr_oe)
    else $error("data driven outside a write");
  data_after_strobe_a: assert property ($rose(data_oe) |-> $past(addr_oe && !address_strobe_n))
    else $error("data phase without first clock");
  data_parity_a: assert property (data_oe |-> wparity == {^wdata[31:24], ^wdata[23:16], ^wdata[15:8], ^wdata[7:0]})
    else $error("bad data parity");
  float_next_a: assert property (backoff_request_n_pipe_q[1] && addr_oe |=> !addr_oe && !data_oe)
    else $error("bus not floated after backoff");
  strobe_float_low_a: assert property (backoff_request_n_pipe_q[1] && addr_oe && !address_strobe_n |=> !address_strobe_n)
    else $error("strobe not left low under backoff");
endmodule
`default_nettype wire

// ### verif/bus_backoff_restart_tb.sv
/*
  bus_backoff_restart_tb: both bus ends joined, random transfers with backoff.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_backoff_restart_tb
  import bbr_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid_i = 1'b0, req_burst_i = 1'b0, backoff_i = 1'b0, hold_addr_i = 1'b0;
  logic ready_i = 1'b0, burst_ready_i = 1'b0, rdy_en = 1'b0, saw_cycle = 1'b0;
  logic [BBR_ADDR_W-1:0] req_addr_i = '0;
  bbr_attr_type req_attr_i = '0;
  logic [BBR_DATA_W-1:0] req_wdata_i = '0, rdata_i = '0, rd_val;
  logic req_ready_o, rsp_valid_o, rsp_last_o, cycle_seen_o, may_drive_o;
  logic [BBR_DATA_W-1:0] rsp_rdata_o;
  logic [BBR_XFER_W-1:0] rsp_index_o;
  int n_errors = 0, num_checks = 0, n_rsp = 0, n_exp = 0;
  bbr_bus_if bbr_bus_if_inst (.core_clk_i(core_clk_i));
  bbr_cpu_end bbr_cpu_end_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(bbr_bus_if_inst),
    .req_valid_i(req_valid_i), .req_addr_i(req_addr_i), .req_attr_i(req_attr_i), .req_burst_i(req_burst_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_index_o(rsp_index_o), .rsp_last_o(rsp_last_o));
  bbr_sys_end bbr_sys_end_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(bbr_bus_if_inst),
    .backoff_i(backoff_i), .hold_addr_i(hold_addr_i), .ready_i(ready_i), .burst_ready_i(burst_ready_i),
    .rdata_i(rdata_i), .cycle_seen_o(cycle_seen_o), .may_drive_o(may_drive_o));
  bbr_checker bbr_checker_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr(bbr_bus_if_inst.addr),
    .attr(bbr_bus_if_inst.attr), .address_strobe_n(bbr_bus_if_inst.address_strobe_n),
    .wdata(bbr_bus_if_inst.wdata), .wparity(bbr_bus_if_inst.wparity), .addr_oe(bbr_bus_if_inst.addr_oe),
    .data_oe(bbr_bus_if_inst.data_oe), .hold_acknowledge(bbr_bus_if_inst.hold_acknowledge),
    .backoff_request_n(bbr_bus_if_inst.backoff_request_n));
  // clock
  always #2 core_clk_i = ~core_clk_i;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // memory side terminations, random stalls, ready kept alive under backoff
  always @(posedge core_clk_i)
  begin
    ready_i <= rdy_en && !req_burst_i && ($urandom_range(3, 0) != 0);
    burst_ready_i <= rdy_en && req_burst_i && ($urandom_range(3, 0) != 0);
  end
  // response monitor: index order, last flag, read data
  always @(posedge core_clk_i)
  begin
    if (cycle_seen_o === 1'b1)
      saw_cycle <= 1'b1;
    if (!srst_i && rsp_valid_o === 1'b1)
    begin
      chk("rsp_index", n_rsp, 32'(rsp_index_o));
      chk("rsp_last", 32'(n_rsp == n_exp - 1), 32'(rsp_last_o));
      if (!req_attr_i.write_not_read)
        chk("rsp_rdata", rd_val, rsp_rdata_o);
      n_rsp++;
    end
  end
  task automatic xfer(input bit bst, input int bo_dly, input int bo_len, input bit two_clk);
    int t;
    n_exp = bst ? 4 : 1;
    n_rsp = 0;
    rd_val = $urandom;
    @(posedge core_clk_i);
    req_burst_i <= bst;
    req_addr_i <= bst ? {28'($urandom), 2'h0} : 30'($urandom);
    req_attr_i <= bbr_attr_type'($urandom);
    req_wdata_i <= $urandom;
    rdata_i <= rd_val;
    req_valid_i <= 1'b1;
    rdy_en <= 1'b1;
    saw_cycle <= 1'b0;
    fork
      begin
        for (t = 0; t < 60 && req_ready_o !== 1'b1; t++)
          @(negedge core_clk_i);
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        for (t = 0; t < 300 && n_rsp < n_exp; t++)
          @(posedge core_clk_i);
      end
      begin
        repeat (bo_dly) @(posedge core_clk_i);
        if (bo_len > 0)
        begin
          hold_addr_i <= two_clk;
          if (two_clk)
            @(posedge core_clk_i);
          backoff_i <= 1'b1;
          rdata_i <= ~rd_val;
          repeat (bo_len) @(posedge core_clk_i);
          backoff_i <= 1'b0;
          hold_addr_i <= 1'b0;
          rdata_i <= rd_val;
        end
      end
    join
    if (n_rsp < n_exp)
    begin
      n_errors++;
      $display("Error rsp_wait expected %0d seen %0d", n_exp, n_rsp);
      complete_run();
    end
    rdy_en <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    chk("rsp_count", n_exp, n_rsp);
    chk("cycle_seen", 32'h1, 32'(saw_cycle));
  endtask
  initial
  begin
    int k;
    int t;
    void'($urandom(32'he96d0191));
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("idle_oe", 32'h0, 32'(bbr_bus_if_inst.addr_oe));
    chk("idle_cycle_seen", 32'h0, 32'(cycle_seen_o));
    @(posedge core_clk_i);
    backoff_i <= 1'b1;
    for (t = 0; t < 6 && may_drive_o !== 1'b1; t++)
      @(negedge core_clk_i);
    chk("may_drive", 32'h1, 32'(may_drive_o));
    chk("may_delay", 32'(BBR_IDLE_START_CLOCKS + 2), 32'(t));
    chk("req_ready", 32'h0, 32'(req_ready_o));
    @(posedge core_clk_i);
    backoff_i <= 1'b0;
    $display("test idle backoff done");
    for (k = 0; k < 30; k++)
    begin
      xfer(k[0], $urandom_range(8, 0), (k < 2) ? 0 : $urandom_range(6, 0), k[2] & k[1]);
      $display("test %0d done", k);
    end
    complete_run();
  end
endmodule
`default_nettype wire
